// >>> verilog/fcd_consts.svh
// Constants for the flow-control and compare execute unit
// What this block does
// RULE1: Direct call loads PC with absolute target, keeps flags, takes 4 cycles.
// RULE2: Subroutine exit reloads PC from stack, keeps flags, takes 4 cycles.
// RULE3: Interrupt exit reloads PC from stack, sets interrupt enable, takes 4 cycles.
// RULE4: Compare-skip skips next instruction on equal operands; 1, 2 or 3 cycles.
// RULE5: Register compare subtracts operands, updates Z N V C H in one cycle.
// RULE6: Compare with carry also subtracts carry; updates Z N V C H, one cycle.
// RULE7: Immediate compare subtracts constant, updates Z N V C H in one cycle.
// RULE8: Skip when chosen working register bit is one; no flags; 1, 2 or 3 cycles.
// RULE9: Skip when chosen port bit is one; no flags; 1, 2 or 3 cycles.
// RULE10: Branch adds offset plus one when chosen flag is one; 1 or 2 cycles.
// RULE11: Branch adds offset plus one when chosen flag is zero; 1 or 2 cycles.
// RULE12: Branch on zero flag set, offset plus one; 1 or 2 cycles.
// RULE13: Branch on zero flag clear, offset plus one; 1 or 2 cycles.
// RULE14: Branch on carry flag clear, offset plus one; 1 or 2 cycles, no flags.
// RULE15: Calls push the following instruction address so the exit resumes there.
`ifndef FCD_CONSTS_SVH
`define FCD_CONSTS_SVH
`define FCD_PC_W 16
`define FCD_FLAG_C 0
`define FCD_FLAG_Z 1
`define FCD_FLAG_N 2
`define FCD_FLAG_V 3
`define FCD_FLAG_H 5
`define FCD_FLAG_I 7
`define FCD_CYC_CALL 3'd4
`define FCD_CYC_EXIT 3'd4
`define FCD_CYC_ONE 3'd1
`define FCD_CYC_TWO 3'd2
`define FCD_CYC_THREE 3'd3
`define FCD_LEN_CALL 16'h0002
`define FCD_STEP 16'h0001
`define FCD_SKIP_SHORT 16'h0002
`define FCD_SKIP_LONG 16'h0003
`endif

// >>> verilog/fcd_pkg.sv
// Types for the flow-control and compare execute unit
package fcd_pkg;
    typedef enum logic [3:0] {
        FCD_CALL = 4'h0,
        FCD_SUB_EXIT = 4'h1,
        FCD_IRQ_EXIT = 4'h2,
        FCD_CMP_SKIP_EQ = 4'h3,
        FCD_CMP_REG = 4'h4,
        FCD_CMP_CARRY = 4'h5,
        FCD_CMP_IMM = 4'h6,
        FCD_SKIP_REG_BIT = 4'h7,
        FCD_SKIP_PORT_BIT = 4'h8,
        FCD_BR_FLAG_SET = 4'h9,
        FCD_BR_FLAG_CLR = 4'hA,
        FCD_BR_ZERO_SET = 4'hB,
        FCD_BR_ZERO_CLR = 4'hC,
        FCD_BR_CARRY_CLR = 4'hD,
        FCD_IRQ_ENTRY = 4'hE
    } fcd_cmd_t;

    typedef enum logic [1:0] {
        FCD_ST_IDLE = 2'b01,
        FCD_ST_RUN = 2'b10
    } fcd_state_t;

    typedef struct packed {
        logic valid;
        fcd_cmd_t cmd;
        logic [7:0] opa;
        logic [7:0] opb;
        logic [7:0] imm;
        logic [2:0] bit_sel;
        logic io_bit;
        logic [6:0] offset;
        logic [15:0] target;
        logic next_long;
    } fcd_req_t;

    typedef struct packed {
        logic done;
        logic pc_load;
        logic [15:0] pc_next;
        logic flags_we;
        logic [7:0] flags;
        logic push;
        logic [15:0] push_data;
        logic pop;
    } fcd_res_t;
endpackage

// >>> verilog/fcd_exec.sv
// Execute unit for calls, returns, compares, skips and branches
`timescale 1ns/1ns
`include "fcd_consts.svh"
module fcd_exec (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Request from fetch and register file
    input wire fcd_pkg::fcd_req_t i_req,
    input wire logic [15:0] i_pc,
    input wire logic [7:0] i_flags,
    input wire logic [15:0] i_stack_top,
    // Results
    output fcd_pkg::fcd_res_t o_res,
    output logic o_busy
);
    fcd_pkg::fcd_state_t state_q, state_d;
    fcd_pkg::fcd_res_t res_q, hold_q, now_res;
    logic busy_q;
    logic [2:0] cnt_q;
    logic [2:0] cyc;
    logic [7:0] cmp_b;
    logic [7:0] diff;
    logic [7:0] cmp_flags;
    logic cin;
    logic accept;
    logic is_cmp;
    logic skip;
    logic br_taken;
    logic [15:0] br_pc;
    logic [15:0] skip_pc;

    function automatic logic borrow(input logic a, input logic b, input logic r);
        borrow = (~a & b) | (b & r) | (r & ~a);
    endfunction

    assign accept = i_req.valid & ~busy_q;
    assign is_cmp = (i_req.cmd == fcd_pkg::FCD_CMP_REG) | (i_req.cmd == fcd_pkg::FCD_CMP_CARRY)
                  | (i_req.cmd == fcd_pkg::FCD_CMP_IMM);

    // Subtraction shared by the three compares
    assign cmp_b = (i_req.cmd == fcd_pkg::FCD_CMP_IMM) ? i_req.imm : i_req.opb; // RULE7
    assign cin = (i_req.cmd == fcd_pkg::FCD_CMP_CARRY) & i_flags[`FCD_FLAG_C]; // RULE6
    assign diff = i_req.opa - cmp_b - {7'h00, cin}; // RULE5

    always_comb
    begin
        cmp_flags = i_flags;
        cmp_flags[`FCD_FLAG_C] = borrow(i_req.opa[7], cmp_b[7], diff[7]);
        cmp_flags[`FCD_FLAG_H] = borrow(i_req.opa[3], cmp_b[3], diff[3]);
        cmp_flags[`FCD_FLAG_N] = diff[7];
        cmp_flags[`FCD_FLAG_V] = (i_req.opa[7] & ~cmp_b[7] & ~diff[7]) | (~i_req.opa[7] & cmp_b[7] & diff[7]);
        // Carry form keeps zero only if it was already set
        cmp_flags[`FCD_FLAG_Z] = (diff == 8'h00) & (~cin & (i_req.cmd != fcd_pkg::FCD_CMP_CARRY)
                               | i_flags[`FCD_FLAG_Z]); // RULE6
    end

    // Skip and branch decisions
    assign skip = ((i_req.cmd == fcd_pkg::FCD_CMP_SKIP_EQ) & (i_req.opa == i_req.opb)) // RULE4
                | ((i_req.cmd == fcd_pkg::FCD_SKIP_REG_BIT) & i_req.opa[i_req.bit_sel]) // RULE8
                | ((i_req.cmd == fcd_pkg::FCD_SKIP_PORT_BIT) & i_req.io_bit); // RULE9
    assign br_taken = ((i_req.cmd == fcd_pkg::FCD_BR_FLAG_SET) & i_flags[i_req.bit_sel]) // RULE10
                    | ((i_req.cmd == fcd_pkg::FCD_BR_FLAG_CLR) & ~i_flags[i_req.bit_sel]) // RULE11
                    | ((i_req.cmd == fcd_pkg::FCD_BR_ZERO_SET) & i_flags[`FCD_FLAG_Z]) // RULE12
                    | ((i_req.cmd == fcd_pkg::FCD_BR_ZERO_CLR) & ~i_flags[`FCD_FLAG_Z]) // RULE13
                    | ((i_req.cmd == fcd_pkg::FCD_BR_CARRY_CLR) & ~i_flags[`FCD_FLAG_C]); // RULE14
    assign br_pc = i_pc + {{9{i_req.offset[6]}}, i_req.offset} + `FCD_STEP;
    assign skip_pc = i_pc + (i_req.next_long ? `FCD_SKIP_LONG : `FCD_SKIP_SHORT);

    // Result and cycle count of the accepted request
    always_comb
    begin
        now_res = '0;
        now_res.done = 1'b1;
        now_res.pc_load = 1'b1;
        now_res.pc_next = i_pc + `FCD_STEP;
        now_res.flags = i_flags;
        cyc = `FCD_CYC_ONE;
        unique case (i_req.cmd)
            fcd_pkg::FCD_CALL, fcd_pkg::FCD_IRQ_ENTRY:
            begin
                now_res.pc_next = i_req.target; // RULE1
                cyc = `FCD_CYC_CALL; // RULE1
            end
            fcd_pkg::FCD_SUB_EXIT:
            begin
                now_res.pc_next = i_stack_top; // RULE2
                now_res.pop = 1'b1;
                cyc = `FCD_CYC_EXIT; // RULE2
            end
            fcd_pkg::FCD_IRQ_EXIT:
            begin
                now_res.pc_next = i_stack_top; // RULE3
                now_res.pop = 1'b1;
                now_res.flags_we = 1'b1;
                now_res.flags[`FCD_FLAG_I] = 1'b1; // RULE3
                cyc = `FCD_CYC_EXIT; // RULE3
            end
            fcd_pkg::FCD_CMP_REG, fcd_pkg::FCD_CMP_CARRY, fcd_pkg::FCD_CMP_IMM:
            begin
                now_res.flags_we = 1'b1; // RULE5
                now_res.flags = cmp_flags;
            end
            fcd_pkg::FCD_CMP_SKIP_EQ, fcd_pkg::FCD_SKIP_REG_BIT, fcd_pkg::FCD_SKIP_PORT_BIT:
            begin
                if (skip)
                begin
                    now_res.pc_next = skip_pc; // RULE4
                    cyc = i_req.next_long ? `FCD_CYC_THREE : `FCD_CYC_TWO; // RULE9
                end
            end
            default:
            begin
                if (br_taken)
                begin
                    now_res.pc_next = br_pc; // RULE10
                    cyc = `FCD_CYC_TWO; // RULE11
                end
            end
        endcase
    end

    assign state_d = (state_q == fcd_pkg::FCD_ST_IDLE)
                   ? ((accept && cyc != `FCD_CYC_ONE) ? fcd_pkg::FCD_ST_RUN : fcd_pkg::FCD_ST_IDLE)
                   : ((cnt_q == 3'd0) ? fcd_pkg::FCD_ST_IDLE : fcd_pkg::FCD_ST_RUN);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            state_q <= fcd_pkg::FCD_ST_IDLE;
            res_q <= '0;
            hold_q <= '0;
            busy_q <= 1'b0;
            cnt_q <= 3'd0;
        end
        else
        begin
            state_q <= state_d;
            res_q <= '0;
            if (accept)
            begin
                // Return address goes out at once, the jump at the end
                res_q.push <= (i_req.cmd == fcd_pkg::FCD_CALL) | (i_req.cmd == fcd_pkg::FCD_IRQ_ENTRY); // RULE15
                res_q.push_data <= (i_req.cmd == fcd_pkg::FCD_CALL) ? i_pc + `FCD_LEN_CALL : i_pc; // RULE15
                if (cyc == `FCD_CYC_ONE)
                begin
                    res_q <= now_res;
                end
                else
                begin
                    hold_q <= now_res;
                    busy_q <= 1'b1;
                    cnt_q <= cyc - 3'd2;
                end
            end
            else if (state_q == fcd_pkg::FCD_ST_RUN)
            begin
                if (cnt_q == 3'd0)
                begin
                    res_q <= hold_q;
                    busy_q <= 1'b0;
                end
                else
                begin
                    cnt_q <= cnt_q - 3'd1;
                end
            end
        end
    end

    assign o_res = res_q;
    assign o_busy = busy_q;

    chk_call_timing: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE1
        accept && i_req.cmd == fcd_pkg::FCD_CALL |-> ##4 (o_res.done && o_res.pc_next == $past(i_req.target, 4)
            && !o_res.flags_we))
        else $error("call target or timing wrong");
    chk_call_push: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE15
        accept && i_req.cmd == fcd_pkg::FCD_CALL |=> o_res.push && o_res.push_data == $past(i_pc) + 16'h0002)
        else $error("call return address wrong");
    chk_exit_stack: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE2
        accept && i_req.cmd == fcd_pkg::FCD_SUB_EXIT |=> !o_res.done [*3] ##1
            (o_res.done && o_res.pc_next == $past(i_stack_top, 4) && !o_res.flags_we))
        else $error("subroutine exit wrong");
    chk_irq_exit_ie: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE3
        accept && i_req.cmd == fcd_pkg::FCD_IRQ_EXIT |-> ##4 (o_res.done && o_res.flags_we
            && o_res.flags[`FCD_FLAG_I]))
        else $error("interrupt exit did not enable interrupts");
    chk_skip_eq_long: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE4
        accept && i_req.cmd == fcd_pkg::FCD_CMP_SKIP_EQ && i_req.opa == i_req.opb && i_req.next_long
            |-> ##3 (o_res.done && o_res.pc_next == $past(i_pc, 3) + 16'h0003 && !o_res.flags_we))
        else $error("compare skip wrong");
    chk_cmp_zero: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE5
        accept && i_req.cmd == fcd_pkg::FCD_CMP_REG |=> o_res.done && o_res.flags_we
            && o_res.flags[`FCD_FLAG_Z] == ($past(i_req.opa) == $past(i_req.opb))
            && o_res.flags[`FCD_FLAG_C] == ($past(i_req.opa) < $past(i_req.opb)))
        else $error("register compare flags wrong");
    chk_carry_cmp: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE6
        accept && i_req.cmd == fcd_pkg::FCD_CMP_CARRY |=> o_res.done
            && o_res.flags[`FCD_FLAG_C] == ({1'b0, $past(i_req.opa)} < {1'b0, $past(i_req.opb)}
            + {8'h00, $past(i_flags[`FCD_FLAG_C])}))
        else $error("compare with carry flag wrong");
    chk_imm_zero: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE7
        accept && i_req.cmd == fcd_pkg::FCD_CMP_IMM |=> o_res.done
            && o_res.flags[`FCD_FLAG_Z] == ($past(i_req.opa) == $past(i_req.imm)))
        else $error("immediate compare flag wrong");
    chk_reg_bit_clear: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE8
        accept && i_req.cmd == fcd_pkg::FCD_SKIP_REG_BIT && !i_req.opa[i_req.bit_sel]
            |=> o_res.done && o_res.pc_next == $past(i_pc) + 16'h0001)
        else $error("register bit skip taken wrongly");
    chk_port_skip_short: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE9
        accept && i_req.cmd == fcd_pkg::FCD_SKIP_PORT_BIT && i_req.io_bit && !i_req.next_long
            |=> !o_res.done ##1 (o_res.done && o_res.pc_next == $past(i_pc, 2) + 16'h0002))
        else $error("port bit skip wrong");
    chk_branch_taken: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE10
        accept && br_taken |=> o_busy ##1 (o_res.done && !o_res.flags_we
            && o_res.pc_next == $past(br_pc, 2)))
        else $error("taken branch wrong");
    chk_zero_clr_fall: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RULE13
        accept && i_req.cmd == fcd_pkg::FCD_BR_ZERO_CLR && i_flags[`FCD_FLAG_Z]
            |=> o_res.done && o_res.pc_next == $past(i_pc) + 16'h0001)
        else $error("branch on zero clear taken wrongly");
endmodule

// >>> tb/fcd_tb.sv
// Self-checking bench for the flow-control and compare execute unit
`timescale 1ns/1ns
`include "fcd_consts.svh"
module tb;
    typedef struct {int lat; logic [15:0] pc; logic fwe; logic [7:0] fl; logic pop; int acc;} fcd_exp_t;
    logic i_sys_clk;
    logic i_sys_rst;
    fcd_pkg::fcd_req_t i_req;
    logic [15:0] i_pc;
    logic [7:0] i_flags;
    logic [15:0] i_stack_top;
    fcd_pkg::fcd_res_t o_res;
    logic o_busy;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    fcd_exp_t eq[$];
    logic [15:0] pq[$];
    fcd_pkg::fcd_cmd_t cmps[3] = '{fcd_pkg::FCD_CMP_REG, fcd_pkg::FCD_CMP_CARRY, fcd_pkg::FCD_CMP_IMM};
    fcd_pkg::fcd_cmd_t skps[3] = '{fcd_pkg::FCD_CMP_SKIP_EQ, fcd_pkg::FCD_SKIP_REG_BIT, fcd_pkg::FCD_SKIP_PORT_BIT};
    fcd_pkg::fcd_cmd_t brs[5] = '{fcd_pkg::FCD_BR_FLAG_SET, fcd_pkg::FCD_BR_FLAG_CLR, fcd_pkg::FCD_BR_ZERO_SET,
        fcd_pkg::FCD_BR_ZERO_CLR, fcd_pkg::FCD_BR_CARRY_CLR};

    fcd_exec uut (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_req(i_req),
        .i_pc(i_pc),
        .i_flags(i_flags),
        .i_stack_top(i_stack_top),
        .o_res(o_res),
        .o_busy(o_busy)
    );

    always #50 i_sys_clk = ~i_sys_clk;

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task close_out();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Subtraction flags; other flag bits kept
    function logic [7:0] cmpf(logic [7:0] f, logic [7:0] a, logic [7:0] b, logic c, logic zk);
        logic [8:0] r;
        logic [4:0] h;
        cmpf = f;
        r = {1'b0, a} - {1'b0, b} - 9'(c);
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(c);
        cmpf[`FCD_FLAG_C] = r[8];
        cmpf[`FCD_FLAG_Z] = (r[7:0] == 8'h00) && (!zk || f[`FCD_FLAG_Z]);
        cmpf[`FCD_FLAG_N] = r[7];
        cmpf[`FCD_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        cmpf[`FCD_FLAG_H] = h[4];
    endfunction

    function fcd_pkg::fcd_req_t rnd(fcd_pkg::fcd_cmd_t c);
        logic [63:0] x;
        x = {$urandom, $urandom};
        rnd = x[56:0];
        rnd.valid = 1'b1;
        rnd.cmd = c;
    endfunction

    task run(input fcd_pkg::fcd_req_t r, input logic [7:0] fl);
        fcd_exp_t e;
        logic [15:0] pc;
        logic [15:0] stk;
        logic tk;
        logic br;
        int n;
        pc = 16'($urandom);
        stk = 16'($urandom);
        tk = 1'b0;
        br = 1'b0;
        e = '{1, pc + `FCD_STEP, 1'b0, fl, 1'b0, 0};
        case (r.cmd)
            fcd_pkg::FCD_CALL: begin e.lat = 4; e.pc = r.target; pq.push_back(pc + `FCD_LEN_CALL); end
            fcd_pkg::FCD_IRQ_ENTRY: begin e.lat = 4; e.pc = r.target; pq.push_back(pc); end
            fcd_pkg::FCD_SUB_EXIT: begin e.lat = 4; e.pc = stk; e.pop = 1'b1; end
            fcd_pkg::FCD_IRQ_EXIT: e = '{4, stk, 1'b1, fl | 8'h80, 1'b1, 0};
            fcd_pkg::FCD_CMP_SKIP_EQ: tk = (r.opa == r.opb);
            fcd_pkg::FCD_CMP_REG: begin e.fwe = 1'b1; e.fl = cmpf(fl, r.opa, r.opb, 1'b0, 1'b0); end
            fcd_pkg::FCD_CMP_CARRY: begin e.fwe = 1'b1; e.fl = cmpf(fl, r.opa, r.opb, fl[0], 1'b1); end
            fcd_pkg::FCD_CMP_IMM: begin e.fwe = 1'b1; e.fl = cmpf(fl, r.opa, r.imm, 1'b0, 1'b0); end
            fcd_pkg::FCD_SKIP_REG_BIT: tk = r.opa[r.bit_sel];
            fcd_pkg::FCD_SKIP_PORT_BIT: tk = r.io_bit;
            fcd_pkg::FCD_BR_FLAG_SET: br = fl[r.bit_sel];
            fcd_pkg::FCD_BR_FLAG_CLR: br = !fl[r.bit_sel];
            fcd_pkg::FCD_BR_ZERO_SET: br = fl[`FCD_FLAG_Z];
            fcd_pkg::FCD_BR_ZERO_CLR: br = !fl[`FCD_FLAG_Z];
            fcd_pkg::FCD_BR_CARRY_CLR: br = !fl[`FCD_FLAG_C];
            default: ;
        endcase
        if (tk)
        begin
            e.lat = r.next_long ? 3 : 2;
            e.pc = pc + (r.next_long ? `FCD_SKIP_LONG : `FCD_SKIP_SHORT);
        end
        if (br)
        begin
            e.lat = 2;
            e.pc = pc + {{9{r.offset[6]}}, r.offset} + `FCD_STEP;
        end
        i_req <= r;
        i_pc <= pc;
        i_flags <= fl;
        i_stack_top <= stk;
        n = 0;
        do
        begin
            @(negedge i_sys_clk);
            n++;
        end
        while (o_busy !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            chk("accept wait", 0, 1);
            close_out();
        end
        @(posedge i_sys_clk);
        e.acc = cyc;
        eq.push_back(e);
    endtask

    task drain(input string nm);
        int n;
        i_req <= '0;
        for (n = 0; n < 20 && (eq.size() > 0 || pq.size() > 0); n++)
            @(posedge i_sys_clk);
        if (n >= 20)
        begin
            chk("result wait", 0, 1);
            close_out();
        end
        $display("test %s done", nm);
    endtask

    // Oldest note against each completed instruction
    always @(negedge i_sys_clk)
    begin
        fcd_exp_t e;
        if (o_res.done === 1'b1)
        begin
            if (eq.size() == 0)
                chk("unexpected done", 1, 0);
            else
            begin
                e = eq.pop_front();
                chk("latency", 32'(cyc - e.acc + 1), 32'(e.lat));
                chk("pc_load", o_res.pc_load, 1);
                chk("pc_next", o_res.pc_next, e.pc);
                chk("flags_we", o_res.flags_we, e.fwe);
                chk("flags", o_res.flags, e.fl);
                chk("pop", o_res.pop, e.pop);
            end
        end
        if (o_res.push === 1'b1)
        begin
            if (pq.size() == 0)
                chk("unexpected push", 1, 0);
            else
                chk("push_data", o_res.push_data, pq.pop_front());
        end
        cyc++;
    end

    initial
    begin
        fcd_pkg::fcd_req_t r;
        i_sys_clk = 1'b0;
        i_sys_rst = 1'b1;
        i_req = '0;
        i_pc = 16'h0000;
        i_flags = 8'h00;
        i_stack_top = 16'h0000;
        void'($urandom(21));
        repeat (3) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        @(negedge i_sys_clk);
        chk("busy after reset", o_busy, 0);
        chk("res after reset", 32'(o_res == '0), 1);
        @(posedge i_sys_clk);
        // Back-to-back; each follower is held while the unit is busy
        run(rnd(fcd_pkg::FCD_CALL), 8'($urandom));
        run(rnd(fcd_pkg::FCD_SUB_EXIT), 8'($urandom));
        run(rnd(fcd_pkg::FCD_IRQ_ENTRY), 8'($urandom));
        run(rnd(fcd_pkg::FCD_IRQ_EXIT), 8'($urandom) & 8'h7F);
        drain("calls");
        for (int i = 0; i < 24; i++)
        begin
            r = rnd(cmps[i % 3]);
            if (i % 4 == 0)
                {r.opb, r.imm} = {r.opa, r.opa};
            if (i < 3)
                {r.opa, r.opb, r.imm} = {8'h80, 8'h01, 8'h01};
            run(r, 8'($urandom));
        end
        drain("compares");
        for (int i = 0; i < 12; i++)
        begin
            r = rnd(skps[i % 3]);
            r.next_long = (i / 6) == 1;
            r.opa[r.bit_sel] = 1'((i / 3) % 2);
            r.opb = ((i / 3) % 2) ? r.opa : ~r.opa;
            r.io_bit = 1'((i / 3) % 2);
            run(r, 8'($urandom));
        end
        drain("skips");
        for (int i = 0; i < 25; i++)
        begin
            r = rnd(brs[i % 5]);
            if (i < 10)
                r.offset = (i < 5) ? 7'h40 : 7'h3F;
            run(r, (i < 5) ? 8'h00 : (i < 10) ? 8'hFF : 8'($urandom));
        end
        drain("branches");
        close_out();
    end
endmodule
